// *** design/ipf_pkg.sv ***
/*
  Constants and types shared by the input pulse filter.
  Assumes a 50 MHz controller clock; all counts are derived from it.
*/
package ipf_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 19;

  // Hard filter grows by 2.4 us per preset step
  localparam int unsigned HARD_STEP_NS = 2400;
  localparam int unsigned HARD_STEP_CYC = (HARD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned I0_ON_BASE_NS = 4000;
  localparam int unsigned I0_ON_BASE_CYC = (I0_ON_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFF_BASE_NS = 6000;
  localparam int unsigned OFF_BASE_CYC = (OFF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IN_ON_BASE_NS = 13000;
  localparam int unsigned IN_ON_BASE_CYC = (IN_ON_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IN_ON_FLOOR_NS = 20000;
  localparam int unsigned IN_ON_FLOOR_CYC = (IN_ON_FLOOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IN_ON_FLOOR_MAX_N = 2;
  localparam int unsigned IN_OFF_FLOOR_US = 120;
  localparam int unsigned IN_OFF_FLOOR_MAX_N = 47;

  localparam logic [7:0] HARD_PRESET_RST = 8'h0A;

  // Soft widths, encoded 0..3
  localparam logic [1:0] SOFT_SEL_0MS = 2'h0;
  localparam logic [1:0] SOFT_SEL_3MS = 2'h1;
  localparam logic [1:0] SOFT_SEL_7MS = 2'h2;
  localparam logic [1:0] SOFT_SEL_10MS = 2'h3;
  localparam logic [1:0] SOFT_SEL_RST = SOFT_SEL_3MS;
  localparam int unsigned SOFT_A_MS = 3;
  localparam int unsigned SOFT_B_MS = 7;
  localparam int unsigned SOFT_C_MS = 10;
  localparam int unsigned FIXED_MS = 3;

  localparam int unsigned NUM_GROUPS = 4;
  localparam logic [7:0] SMALL_UNIT_MASK = 8'h3F;
  localparam logic [7:0] FULL_UNIT_MASK = 8'hFF;

  typedef enum logic {
    IPF_CFG_IDLE,
    IPF_CFG_PENDING
  } ipf_cfg_state_t;
endpackage : ipf_pkg

// *** design/ipf_debounce.sv ***
/*
  Saturating-counter pulse filter for one input with separate rise and fall widths.
  Assumes the input is synchronous to clk_i and the widths are stable between loads.
*/
`timescale 1ns/1ps
module ipf_debounce (
  input wire logic clk_i, // Controller clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic d_i, // Raw level
  input wire logic [ipf_pkg::CNT_W-1:0] on_cyc_i, // Cycles a high level must hold
  input wire logic [ipf_pkg::CNT_W-1:0] off_cyc_i, // Cycles a low level must hold
  output logic q_o // Filtered level
);
  logic [ipf_pkg::CNT_W-1:0] cnt;
  logic [ipf_pkg::CNT_W-1:0] need;
  logic [ipf_pkg::CNT_W-1:0] next_cnt;

  assign need = d_i ? on_cyc_i : off_cyc_i; // [R14]
  // Saturate so a width lowered mid-pulse cannot wrap the count
  assign next_cnt = (cnt == {ipf_pkg::CNT_W{1'b1}}) ? cnt : cnt + 1'b1;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '0;
      q_o <= 1'b0;
    end else if (d_i == q_o) begin
      cnt <= '0; // [R1]
    end else if (next_cnt >= need) begin // [R9]
      cnt <= '0;
      q_o <= d_i; // [R18]
    end else begin
      cnt <= next_cnt; // [R1]
    end
  end
endmodule : ipf_debounce

// *** design/ipf_cfg.sv ***
/*
  Filter setting store: captures a load, applies it at the next scan boundary.
  Assumes load and clear are one-cycle strobes from the program loader side.
*/
`timescale 1ns/1ps
module ipf_cfg (
  input wire logic clk_i, // Controller clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic load_i, // Load new settings, pulse
  input wire logic clear_i, // Return to defaults, pulse
  input wire logic scan_end_i, // End of program scan, pulse
  input wire logic [7:0] preset_i, // Hard preset to load
  input wire logic [7:0] soft_sel_i, // Four soft selects to load
  output logic [7:0] preset_o, // Active hard preset
  output logic [7:0] soft_sel_o, // Active soft selects
  output logic pending_o // Load waiting for scan end
);
  ipf_pkg::ipf_cfg_state_t state;
  logic [7:0] stage_preset;
  logic [7:0] stage_soft;

  assign pending_o = (state == ipf_pkg::IPF_CFG_PENDING);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ipf_pkg::IPF_CFG_IDLE;
      stage_preset <= ipf_pkg::HARD_PRESET_RST;
      stage_soft <= {ipf_pkg::NUM_GROUPS{ipf_pkg::SOFT_SEL_RST}};
    end else if (clear_i) begin
      state <= ipf_pkg::IPF_CFG_PENDING;
      stage_preset <= ipf_pkg::HARD_PRESET_RST; // [R3]
      stage_soft <= {ipf_pkg::NUM_GROUPS{ipf_pkg::SOFT_SEL_RST}}; // [R4]
    end else if (load_i) begin
      state <= ipf_pkg::IPF_CFG_PENDING;
      stage_preset <= preset_i; // [R3]
      stage_soft <= soft_sel_i;
    end else begin
      case (state)
        ipf_pkg::IPF_CFG_PENDING: begin
          if (scan_end_i) begin
            state <= ipf_pkg::IPF_CFG_IDLE;
          end
        end
        default: begin
          state <= ipf_pkg::IPF_CFG_IDLE;
        end
      endcase
    end
  end

  // Settings move only at a scan boundary, never while a load is arriving
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      preset_o <= ipf_pkg::HARD_PRESET_RST;
      soft_sel_o <= {ipf_pkg::NUM_GROUPS{ipf_pkg::SOFT_SEL_RST}};
    end else if (pending_o && scan_end_i && !load_i && !clear_i) begin
      preset_o <= stage_preset; // [R19]
      soft_sel_o <= stage_soft; // [R19]
    end
  end
endmodule : ipf_cfg

// *** design/ipf_top.sv ***
/*
  Input pulse filter for the digital inputs: hard, soft and fixed filters with scan sampling.
  Assumes raw inputs are already synchronous to clk_i and scan_end_i pulses once per scan.
*/
`timescale 1ns/1ps
// Summary of operation
// [R1] Pulses shorter than the selected width never change the filtered state.
// [R2] Catch and counter paths use hard filter only; normal reads use both.
// [R3] Hard preset is 0 to 255, default 10 after clearing settings.
// [R4] Soft width is 0, 3, 7 or 10 ms, default 3 ms.
// [R5] Inputs ten to fifteen and expansion inputs use a fixed 3 ms filter.
// [R6] Normal inputs need the filter width plus one scan to be seen.
// [R7] Input zero hard span: ON about 4-616 us, OFF about 6-618 us.
// [R8] Inputs one to seven hard span: ON about 20-625, OFF 120-618 us.
// [R9] Widths fall in reject, indefinite or accept bands per filter.
// [R10] Input zero ON accept above 2.4N+4 us, reject below 0.8N-1 us.
// [R11] Inputs one-seven: ON accept 20 or 2.4N+13; OFF accept 120 or 2.4N+6.
// [R12] Default preset: catch ON 28/37 us, OFF 30/120 us minimum.
// [R13] Default preset: counters a and d to 10 kHz, b and c to 5 kHz.
// [R14] Higher preset lowers counter frequency; too low invites noise trouble.
// [R15] Soft width zero leaves only the hard filter for that group.
// [R16] Soft groups: input zero, input one, inputs two-three, inputs four-seven.
// [R17] On the ten-point unit group four holds only inputs four and five.
// [R18] Each filter is a saturating counter; output follows after a held level.
// [R19] Settings change only from a stable load, without glitching outputs.
module ipf_top #(
  parameter int unsigned SOFT_A_CYC = ipf_pkg::SOFT_A_MS * ipf_pkg::CYC_PER_MS, // 3 ms
  parameter int unsigned SOFT_B_CYC = ipf_pkg::SOFT_B_MS * ipf_pkg::CYC_PER_MS, // 7 ms
  parameter int unsigned SOFT_C_CYC = ipf_pkg::SOFT_C_MS * ipf_pkg::CYC_PER_MS, // 10 ms
  parameter int unsigned FIXED_CYC = ipf_pkg::FIXED_MS * ipf_pkg::CYC_PER_MS, // 3 ms
  parameter int unsigned IN_OFF_FLOOR_CYC = ipf_pkg::IN_OFF_FLOOR_US * 1000 / ipf_pkg::CLK_PERIOD_NS // 120 us
) (
  input wire logic clk_i, // Controller clock, 50 MHz
  input wire logic resetn_i, // Async reset, active low
  input wire logic [7:0] raw_in_i, // Raw inputs zero to seven
  input wire logic [5:0] raw_aux_i, // Raw base inputs ten to fifteen
  input wire logic [15:0] raw_exp_i, // Raw expansion-station inputs
  input wire logic scan_end_i, // End of program scan, pulse
  input wire logic small_unit_i, // Ten-point base unit fitted
  input wire logic cfg_load_i, // Load filter setup, pulse
  input wire logic cfg_clear_i, // Clear filter setup to defaults, pulse
  input wire logic [7:0] hard_preset_i, // Hard preset to load
  input wire logic [7:0] soft_sel_i, // Soft selects, two bits per group
  output logic [7:0] fast_o, // Hard-filtered levels for catch and counters
  output logic [7:0] normal_o, // Scan-sampled normal inputs zero to seven
  output logic [5:0] aux_o, // Scan-sampled inputs ten to fifteen
  output logic [15:0] exp_o, // Scan-sampled expansion inputs
  output logic [7:0] hard_preset_o, // Active hard preset
  output logic [7:0] soft_sel_o, // Active soft selects
  output logic cfg_pending_o // Setup load awaiting scan end
);
  logic [7:0] present;
  logic [7:0] gated_in;
  logic [7:0] hard_q;
  logic [7:0] soft_q;
  logic [7:0] normal_src;
  logic [5:0] aux_q;
  logic [15:0] exp_q;
  logic [7:0] act_preset;
  logic [7:0] act_soft;
  logic [ipf_pkg::CNT_W-1:0] fixed_cyc;

  // Rise width of the hard filter for input idx at preset n
  function automatic logic [ipf_pkg::CNT_W-1:0] hard_on_cyc(input int unsigned idx, input logic [7:0] n);
    int unsigned c;
    c = 0;
    if (idx == 0) begin
      c = n * ipf_pkg::HARD_STEP_CYC + ipf_pkg::I0_ON_BASE_CYC; // [R10]
    end else if (n <= ipf_pkg::IN_ON_FLOOR_MAX_N) begin
      c = ipf_pkg::IN_ON_FLOOR_CYC; // [R11]
    end else begin
      c = n * ipf_pkg::HARD_STEP_CYC + ipf_pkg::IN_ON_BASE_CYC; // [R11]
    end
    return c[ipf_pkg::CNT_W-1:0];
  endfunction : hard_on_cyc

  // Fall width of the hard filter for input idx at preset n
  function automatic logic [ipf_pkg::CNT_W-1:0] hard_off_cyc(input int unsigned idx, input logic [7:0] n);
    int unsigned c;
    c = 0;
    if (idx != 0 && n <= ipf_pkg::IN_OFF_FLOOR_MAX_N) begin
      c = IN_OFF_FLOOR_CYC; // [R11]
    end else begin
      c = n * ipf_pkg::HARD_STEP_CYC + ipf_pkg::OFF_BASE_CYC; // [R7]
    end
    return c[ipf_pkg::CNT_W-1:0];
  endfunction : hard_off_cyc

  // Soft group of input idx
  function automatic int unsigned group_of(input int unsigned idx);
    int unsigned g;
    g = 3;
    if (idx == 0) begin
      g = 0; // [R16]
    end else if (idx == 1) begin
      g = 1;
    end else if (idx <= 3) begin
      g = 2;
    end
    return g;
  endfunction : group_of

  // Soft width in cycles for one two-bit select
  function automatic logic [ipf_pkg::CNT_W-1:0] soft_cyc(input logic [1:0] sel);
    int unsigned c;
    c = 0;
    case (sel)
      ipf_pkg::SOFT_SEL_3MS: c = SOFT_A_CYC; // [R4]
      ipf_pkg::SOFT_SEL_7MS: c = SOFT_B_CYC;
      ipf_pkg::SOFT_SEL_10MS: c = SOFT_C_CYC;
      default: c = 0;
    endcase
    return c[ipf_pkg::CNT_W-1:0];
  endfunction : soft_cyc

  ipf_cfg u_cfg (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(cfg_load_i),
    .clear_i(cfg_clear_i),
    .scan_end_i(scan_end_i),
    .preset_i(hard_preset_i),
    .soft_sel_i(soft_sel_i),
    .preset_o(act_preset),
    .soft_sel_o(act_soft),
    .pending_o(cfg_pending_o)
  );

  assign hard_preset_o = act_preset;
  assign soft_sel_o = act_soft;

  // Absent inputs six and seven on the ten-point unit read as off
  assign present = small_unit_i ? ipf_pkg::SMALL_UNIT_MASK : ipf_pkg::FULL_UNIT_MASK; // [R17]
  assign gated_in = raw_in_i & present; // [R17]
  assign fixed_cyc = FIXED_CYC[ipf_pkg::CNT_W-1:0];

  // Higher presets stretch both widths, so counters top out at lower rates;
  // at the default preset input zero needs 28 us high, inputs one-seven 37 us.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_in
      ipf_debounce u_hard (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(gated_in[gi]),
        .on_cyc_i(hard_on_cyc(gi, act_preset)), // [R8]
        .off_cyc_i(hard_off_cyc(gi, act_preset)), // [R12]
        .q_o(hard_q[gi]) // [R13]
      );

      ipf_debounce u_soft (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(hard_q[gi]),
        .on_cyc_i(soft_cyc(act_soft[2*group_of(gi) +: 2])),
        .off_cyc_i(soft_cyc(act_soft[2*group_of(gi) +: 2])),
        .q_o(soft_q[gi])
      );

      // Zero width bypasses the soft stage rather than adding a cycle
      assign normal_src[gi] = (act_soft[2*group_of(gi) +: 2] == ipf_pkg::SOFT_SEL_0MS) ?
                              hard_q[gi] : soft_q[gi]; // [R15]
    end

    for (gi = 0; gi < 6; gi++) begin : g_aux
      ipf_debounce u_fixed (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(raw_aux_i[gi]),
        .on_cyc_i(fixed_cyc), // [R5]
        .off_cyc_i(fixed_cyc),
        .q_o(aux_q[gi])
      );
    end

    for (gi = 0; gi < 16; gi++) begin : g_exp
      ipf_debounce u_fixed (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(raw_exp_i[gi]),
        .on_cyc_i(fixed_cyc), // [R5]
        .off_cyc_i(fixed_cyc),
        .q_o(exp_q[gi])
      );
    end
  endgenerate

  // Catch and counter consumers see the hard stage one register later
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fast_o <= 8'h00;
    end else begin
      fast_o <= hard_q; // [R2]
    end
  end

  // Normal reads are taken once per scan, which adds the extra scan of delay
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      normal_o <= 8'h00;
      aux_o <= 6'h00;
      exp_o <= 16'h0000;
    end else if (scan_end_i) begin
      normal_o <= normal_src; // [R6]
      aux_o <= aux_q; // [R6]
      exp_o <= exp_q;
    end
  end
endmodule : ipf_top

// *** test/ipf_top_sva.sv ***
/* Checker for ipf_top: scan sampling, config staging, hard widths on input zero, unit mask.
   Assumes one clock domain and one-cycle strobes. */
`timescale 1ns/1ps
module ipf_chk (
  input wire logic clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic [7:0] raw_in_i, // Raw inputs
  input wire logic scan_end_i, // Scan end
  input wire logic small_unit_i, // Small unit
  input wire logic cfg_load_i, // Load strobe
  input wire logic cfg_clear_i, // Clear strobe
  input wire logic [7:0] fast_o, // Hard path
  input wire logic [7:0] normal_o, // Normal path
  input wire logic [5:0] aux_o, // Fixed path
  input wire logic [15:0] exp_o, // Fixed path
  input wire logic [7:0] hard_preset_o, // Active preset
  input wire logic [7:0] soft_sel_o, // Active selects
  input wire logic cfg_pending_o // Staged load
);
  logic [9:0] hi0;
  logic [9:0] lo0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Saturating run lengths, so long holds never wrap into a false short run
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi0 <= 10'h000;
      lo0 <= 10'h000;
    end else begin
      hi0 <= raw_in_i[0] ? hi0 + {9'h000, hi0 != 10'h3FF} : 10'h000;
      lo0 <= raw_in_i[0] ? 10'h000 : lo0 + {9'h000, lo0 != 10'h3FF};
    end
  end
  a_normal_on_scan: assert property ($changed(normal_o) |-> $past(scan_end_i))
    else $error("normal inputs changed outside scan end");
  a_fixed_on_scan: assert property ($changed({aux_o, exp_o}) |-> $past(scan_end_i))
    else $error("fixed inputs changed outside scan end");
  a_cfg_apply_scan: assert property ($changed({hard_preset_o, soft_sel_o}) |-> $past(scan_end_i) && $past(cfg_pending_o))
    else $error("settings changed without staged load at scan end");
  a_pend_on_load: assert property (cfg_load_i || cfg_clear_i |=> cfg_pending_o)
    else $error("pending not raised after load");
  a_pend_applied: assert property (cfg_pending_o && scan_end_i && !cfg_load_i && !cfg_clear_i |=> !cfg_pending_o)
    else $error("pending not dropped at scan end");
  a_on_run_zero: assert property ($rose(fast_o[0]) |-> hi0 >= 10'h0C8)
    else $error("input zero rose after too short a high run");
  a_off_run_zero: assert property ($fell(fast_o[0]) |-> lo0 >= 10'h12C)
    else $error("input zero fell after too short a low run");
  a_small_mask: assert property ($rose(fast_o[6]) || $rose(fast_o[7]) |-> !$past(small_unit_i, 2))
    else $error("masked input rose on small unit");
  a_clear_dflt: assert property (cfg_clear_i ##1 (scan_end_i && !cfg_load_i && !cfg_clear_i)
    |=> hard_preset_o == ipf_pkg::HARD_PRESET_RST && soft_sel_o == {4{ipf_pkg::SOFT_SEL_RST}})
    else $error("clear did not restore defaults");
  c_fast: cover property ($rose(fast_o[0]));
  c_normal: cover property ($rose(normal_o[0]));
  c_exp: cover property ($rose(exp_o[0]));
endmodule : ipf_chk

bind ipf_top ipf_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .raw_in_i(raw_in_i), .scan_end_i(scan_end_i),
  .small_unit_i(small_unit_i), .cfg_load_i(cfg_load_i), .cfg_clear_i(cfg_clear_i), .fast_o(fast_o),
  .normal_o(normal_o), .aux_o(aux_o), .exp_o(exp_o), .hard_preset_o(hard_preset_o),
  .soft_sel_o(soft_sel_o), .cfg_pending_o(cfg_pending_o));

// *** test/ipf_sensor.sv ***
/* Sensor and switch model driving the raw input levels.
   Assumes put is called just after a rising clock edge. */
`timescale 1ns/1ps
module ipf_sensor (
  output logic [7:0] in_o, // Inputs zero to seven
  output logic [5:0] aux_o, // Inputs ten to fifteen
  output logic [15:0] exp_o // Expansion inputs
);
  initial begin
    in_o = 8'h00;
    aux_o = 6'h00;
    exp_o = 16'h0000;
  end
  // Index 0-7 main, 8-13 base extra, 14-29 expansion; bounce is built by the caller
  task automatic put(input int i, input logic l);
    if (i < 8) in_o[i] <= l;
    else if (i < 14) aux_o[i-8] <= l;
    else exp_o[i-14] <= l;
  endtask : put
endmodule : ipf_sensor

// *** test/input_pulse_filter_bench.sv ***
/* Self-checking bench for ipf_top with shortened soft, fixed and OFF floor counts.
   Assumes ipf_sensor supplies the raw levels. */
`timescale 1ns/1ps
module input_pulse_filter_bench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic scan_end_i = 1'b0;
  logic small_unit_i = 1'b0;
  logic cfg_load_i = 1'b0;
  logic cfg_clear_i = 1'b0;
  logic [7:0] hard_preset_i = 8'h00;
  logic [7:0] soft_sel_i = 8'h00;
  logic [7:0] raw_in, fast_o, normal_o, hard_preset_o, soft_sel_o;
  logic [5:0] raw_aux, aux_o;
  logic [15:0] raw_exp, exp_o;
  logic cfg_pending_o;
  int err_total = 0;
  int n_checks = 0;
  always #10 clk_i = ~clk_i;
  ipf_sensor snr (.in_o(raw_in), .aux_o(raw_aux), .exp_o(raw_exp));
  ipf_top #(.SOFT_A_CYC(30), .SOFT_B_CYC(70), .SOFT_C_CYC(100), .FIXED_CYC(30), .IN_OFF_FLOOR_CYC(40)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .raw_in_i(raw_in), .raw_aux_i(raw_aux), .raw_exp_i(raw_exp),
    .scan_end_i(scan_end_i), .small_unit_i(small_unit_i), .cfg_load_i(cfg_load_i), .cfg_clear_i(cfg_clear_i),
    .hard_preset_i(hard_preset_i), .soft_sel_i(soft_sel_i), .fast_o(fast_o), .normal_o(normal_o),
    .aux_o(aux_o), .exp_o(exp_o), .hard_preset_o(hard_preset_o), .soft_sel_o(soft_sel_o),
    .cfg_pending_o(cfg_pending_o));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic scan;
    @(posedge clk_i);
    scan_end_i <= 1'b1;
    @(posedge clk_i);
    scan_end_i <= 1'b0;
    #1;
  endtask : scan
  // Strobe then scan at once, so the staged value is applied on the very next edge
  task automatic cfg(input logic clr, input logic [7:0] p, input logic [7:0] s);
    @(posedge clk_i);
    cfg_clear_i <= clr;
    cfg_load_i <= !clr;
    hard_preset_i <= p;
    soft_sel_i <= s;
    @(posedge clk_i);
    cfg_clear_i <= 1'b0;
    cfg_load_i <= 1'b0;
    scan_end_i <= 1'b1;
    #1;
    chk("pending", cfg_pending_o, 1'b1);
    @(posedge clk_i);
    scan_end_i <= 1'b0;
    #1;
    chk("pending", cfg_pending_o, 1'b0);
  endtask : cfg
  // Edges from the level change to the hard-path output following it
  task automatic meas(input int i, input logic l, input int w);
    int n;
    n = 0;
    @(posedge clk_i);
    snr.put(i, l);
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (fast_o[i] !== l && n < 3000);
    chk("hard_width", n, w + 1);
  endtask : meas
  task automatic pulse(input int i, input int w);
    @(posedge clk_i);
    snr.put(i, 1'b1);
    repeat (w) @(posedge clk_i);
    snr.put(i, 1'b0);
  endtask : pulse
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("preset", hard_preset_o, 8'h0A);
    chk("soft", soft_sel_o, 8'h55);
    cfg(1'b0, 8'h00, 8'h00);
    chk("preset", hard_preset_o, 8'h00);
    meas(0, 1'b1, 200);
    meas(0, 1'b0, 300);
    meas(1, 1'b1, 1000);
    meas(1, 1'b0, 40);
    cfg(1'b0, 8'h03, 8'h00);
    meas(0, 1'b1, 560);
    meas(0, 1'b0, 660);
    meas(1, 1'b1, 1010);
    meas(1, 1'b0, 40);
    pulse(0, 559);
    repeat (5) @(posedge clk_i);
    #1;
    chk("reject", fast_o[0], 1'b0);
    cfg(1'b0, 8'h00, 8'h00);
    @(posedge clk_i);
    snr.put(0, 1'b1);
    repeat (205) @(posedge clk_i);
    #1;
    chk("no_scan", normal_o[0], 1'b0);
    scan;
    chk("bypass", normal_o[0], 1'b1);
    cfg(1'b0, 8'h00, 8'h01);
    @(posedge clk_i);
    snr.put(0, 1'b0);
    repeat (305) @(posedge clk_i);
    scan;
    chk("soft_hold", normal_o[0], 1'b1);
    repeat (40) @(posedge clk_i);
    scan;
    chk("soft_3", normal_o[0], 1'b0);
    // Group two alone gets 7 ms, so input one lags its hard stage by the soft width
    cfg(1'b0, 8'h00, 8'h08);
    @(posedge clk_i);
    snr.put(1, 1'b1);
    repeat (1050) @(posedge clk_i);
    scan;
    chk("group2_hold", normal_o[1], 1'b0);
    repeat (20) @(posedge clk_i);
    scan;
    chk("soft_7", normal_o[1], 1'b1);
    cfg(1'b0, 8'h00, 8'hC0);
    @(posedge clk_i);
    snr.put(2, 1'b1);
    snr.put(4, 1'b1);
    repeat (1010) @(posedge clk_i);
    scan;
    chk("group3", normal_o[2], 1'b1);
    chk("group4", normal_o[4], 1'b0);
    chk("fast4", fast_o[4], 1'b1);
    repeat (110) @(posedge clk_i);
    scan;
    chk("soft_10", normal_o[4], 1'b1);
    pulse(8, 29);
    pulse(14, 29);
    scan;
    chk("fix_rej", {aux_o[0], exp_o[0]}, 2'h0);
    pulse(8, 40);
    @(posedge clk_i);
    snr.put(14, 1'b1);
    repeat (35) @(posedge clk_i);
    scan;
    chk("fix_acc", {aux_o[0], exp_o[0]}, 2'h1);
    @(posedge clk_i);
    small_unit_i <= 1'b1;
    snr.put(6, 1'b1);
    repeat (1010) @(posedge clk_i);
    scan;
    chk("mask", {fast_o[6], normal_o[6], fast_o[4]}, 3'h1);
    @(posedge clk_i);
    small_unit_i <= 1'b0;
    repeat (1010) @(posedge clk_i);
    #1;
    chk("unmask", fast_o[6], 1'b1);
    cfg(1'b1, 8'h00, 8'h00);
    chk("clr", {hard_preset_o, soft_sel_o}, 16'h0A55);
    final_report;
  end
endmodule : input_pulse_filter_bench
